//--- logic/vds_defs.svh
// Register offsets, field positions, reset values and timing figures of the slicer
`ifndef VDS_DEFS_SVH
`define VDS_DEFS_SVH
`define VDS_ADR_GCFG 8'h40
`define VDS_ADR_LSEL_FIRST 8'h41
`define VDS_ADR_LSEL_LAST 8'h57
`define VDS_ADR_HORIZ_OFFSET_LOW_LO 8'h59
`define VDS_ADR_VERT_OFFSET_LOW_LO 8'h5A
`define VDS_ADR_OFF_HI 8'h5B
`define VDS_ADR_PROG_FC 8'h5C
`define VDS_ADR_STATUS 8'h5E
`define VDS_ADR_TYPE_SEL 8'h62
`define VDS_HORIZ_OFFSET_LOW_HI_MSB 2
`define VDS_VERT_OFFSET_LOW_HI_BIT 4
`define VDS_FIELD_SLICE_OFFSET_BIT 7
`define VDS_TOL_MSB 3
`define VDS_HAM_EN_BIT 4
`define VDS_LSEL_RST 8'hFF
`define VDS_REG_RST 8'h00
`define VDS_FIRST_LINE 2
`define VDS_LAST_LINE 24
`define VDS_NUM_LSEL 23
`define VDS_SEC_BYTES 56
`define VDS_NUM_SEC 2
`define VDS_CLK_HZ 100000000
`define VDS_RATE_TTX625 6937500
`define VDS_RATE_TTX525 5727200
`define VDS_RATE_CC625 500000
`define VDS_RATE_CC525 503000
`define VDS_RATE_5M 5000000
`define VDS_RATE_VITC625 1812500
`define VDS_RATE_VITC525 1789800
`define VDS_FC_TTX 24'h000027
`define VDS_FC_CC 24'h000004
`define VDS_FC_VPS 24'h009951
`define VDS_FC_WSS 24'h1E3C1F
`define VDS_FC_LEN_TTX 5'd8
`define VDS_FC_LEN_CC 5'd3
`define VDS_FC_LEN_VPS 5'd16
`define VDS_FC_LEN_WSS 5'd24
`define VDS_WIN_TTX 8'd40
`define VDS_WIN_CC 8'd24
`define VDS_WIN_VPS 8'd40
`define VDS_WIN_WSS 8'd48
`define VDS_WIN_VITC 8'd24
`define VDS_NB_TTX625 6'd42
`define VDS_NB_TTX525 6'd34
`define VDS_NB_CC 6'd2
`define VDS_NB_VPS 6'd13
`define VDS_NB_WSS 6'd2
`define VDS_NB_RAW 6'd56
`define VDS_NB_VITC 6'd9
`define VDS_HAM_BYTES 6'd2
`define VDS_PHASE_HALF 24'h800000
`endif

//--- logic/vds_pkg.sv
// Types shared by the slicer
package vds_pkg;
   typedef enum logic [1:0] {
      VDS_HAM_NONE = 2'h0,
      VDS_HAM_ALWAYS = 2'h1,
      VDS_HAM_OPTIONAL = 2'h2
   } vds_ham_t;

   typedef enum logic [1:0] {
      VDS_ST_WAIT = 2'h0,
      VDS_ST_SEARCH = 2'h1,
      VDS_ST_COLLECT = 2'h3,
      VDS_ST_DONE = 2'h2
   } vds_state_t;

   typedef struct packed {
      logic [23:0] inc;
      logic [23:0] pat;
      logic [4:0] pat_len;
      logic [7:0] win;
      logic [5:0] nbytes;
      vds_ham_t ham;
   } vds_std_t;
endpackage

//--- logic/vds_slicer.sv
// VBI data slicer: bit recovery, framing search, byte packing, line buffer and output FIFO
// Operation
// - During run-in the bit phase is realigned on each slice crossing not on a sampling clock, then bits are sampled and packed to bytes.
// - Sliced bytes are held in two line sections of 56 bytes each.
// - Lines 2 to 24 each take one of 16 standard codes, a 4-bit code per field from the line selection registers.
// - The line-24 code stays in force for every later line of the field until the next field starts.
// - The horizontal offset is 11 bits: upper three in the shared offset register, lower eight in their own.
// - The vertical offset is 9 bits with its top bit in bit 4 of the shared register; bit 7 there is the field offset.
// - Offsets are counted from the falling edges of the horizontal reference and the vertical timing pulse.
// - Codes 0000/0100 are teletext with framing 27h and Hamming always; 1000/1100 use a programmable framing code.
// - Codes 0001 and 0101 are closed caption at 0.500 and 0.503 Mbit/s with framing pattern 001.
// - Codes 0010/0011 are VPS and WSS at 5 Mbit/s; 0111 has no framing; 0110 slices nothing; 1011 is reserved.
// - Codes 1001 and 1010 are time codes at 1.8125 and 1.7898 Mbit/s with programmable framing.
// - A whole line fills one section before it is offered for transfer, while the other section collects.
`include "vds_defs.svh"

module vds_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = cnt_r != FULL_CNT;
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module vds_slicer #(
   parameter int FIFO_WIDTH = 8,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] vid_sample,
   input wire logic horiz_reference,
   input wire logic vert_timing_pulse,
   input wire logic field_id,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic out_valid,
   output logic [FIFO_WIDTH-1:0] out_data,
   input wire logic out_ready,
   output logic line_avail
);
   localparam logic [6:0] SEC_BYTES = 7'(`VDS_SEC_BYTES);
   localparam logic [8:0] FIRST_LINE = 9'(`VDS_FIRST_LINE);
   localparam logic [8:0] LAST_LINE = 9'(`VDS_LAST_LINE);

   function automatic logic [23:0] vds_inc(input longint rate);
      vds_inc = 24'((rate * 64'd16777216) / `VDS_CLK_HZ);
   endfunction

   // Uncorrectable or flagged byte of a Hamming 8/4 protected field
   function automatic logic vds_ham_bad(input logic [7:0] b);
      vds_ham_bad = !((b[0] ^ b[1] ^ b[5] ^ b[7]) && (b[1] ^ b[2] ^ b[3] ^ b[7]) &&
                      (b[1] ^ b[3] ^ b[4] ^ b[5]) && (^b));
   endfunction

   function automatic vds_pkg::vds_std_t vds_lookup(input logic [3:0] code, input logic [7:0] prog);
      vds_pkg::vds_std_t s;
      s = '0;
      case (code)
         4'h0: s = '{vds_inc(`VDS_RATE_TTX625), `VDS_FC_TTX, `VDS_FC_LEN_TTX, `VDS_WIN_TTX,
                     `VDS_NB_TTX625, vds_pkg::VDS_HAM_ALWAYS};
         4'h4: s = '{vds_inc(`VDS_RATE_TTX525), `VDS_FC_TTX, `VDS_FC_LEN_TTX, `VDS_WIN_TTX,
                     `VDS_NB_TTX525, vds_pkg::VDS_HAM_ALWAYS};
         4'h8: s = '{vds_inc(`VDS_RATE_TTX625), {16'h0000, prog}, `VDS_FC_LEN_TTX, `VDS_WIN_TTX,
                     `VDS_NB_TTX625, vds_pkg::VDS_HAM_OPTIONAL};
         4'hC: s = '{vds_inc(`VDS_RATE_TTX525), {16'h0000, prog}, `VDS_FC_LEN_TTX, `VDS_WIN_TTX,
                     `VDS_NB_TTX525, vds_pkg::VDS_HAM_OPTIONAL};
         4'h1: s = '{vds_inc(`VDS_RATE_CC625), `VDS_FC_CC, `VDS_FC_LEN_CC, `VDS_WIN_CC,
                     `VDS_NB_CC, vds_pkg::VDS_HAM_NONE};
         4'h5: s = '{vds_inc(`VDS_RATE_CC525), `VDS_FC_CC, `VDS_FC_LEN_CC, `VDS_WIN_CC,
                     `VDS_NB_CC, vds_pkg::VDS_HAM_NONE};
         4'h2: s = '{vds_inc(`VDS_RATE_5M), `VDS_FC_VPS, `VDS_FC_LEN_VPS, `VDS_WIN_VPS,
                     `VDS_NB_VPS, vds_pkg::VDS_HAM_NONE};
         4'h3: s = '{vds_inc(`VDS_RATE_5M), `VDS_FC_WSS, `VDS_FC_LEN_WSS, `VDS_WIN_WSS,
                     `VDS_NB_WSS, vds_pkg::VDS_HAM_NONE};
         // Raw data: no framing, window off, section filled from the second sampled bit
         4'h7: s = '{vds_inc(`VDS_RATE_5M), 24'h000000, 5'd0, 8'd0,
                     `VDS_NB_RAW, vds_pkg::VDS_HAM_NONE};
         4'h9: s = '{vds_inc(`VDS_RATE_VITC625), {16'h0000, prog}, `VDS_FC_LEN_TTX, `VDS_WIN_VITC,
                     `VDS_NB_VITC, vds_pkg::VDS_HAM_NONE};
         4'hA: s = '{vds_inc(`VDS_RATE_VITC525), {16'h0000, prog}, `VDS_FC_LEN_TTX, `VDS_WIN_VITC,
                     `VDS_NB_VITC, vds_pkg::VDS_HAM_NONE};
         // Video, reserved and unlisted codes slice nothing
         default: s = '0;
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] gcfg_r;
   logic [7:0] lsel_r [`VDS_NUM_LSEL];
   logic [7:0] horiz_offset_low_lo_r;
   logic [7:0] vert_offset_low_lo_r;
   logic [7:0] off_hi_r;
   logic [7:0] prog_fc_r;
   logic [7:0] type_sel_r;
   logic [3:0] last_err_r;
   logic [1:0] sec_full_r;
   logic [7:0] lsel_idx;
   logic [10:0] horiz_offset_low;
   logic [8:0] vert_offset_low;

   assign lsel_idx = reg_addr - `VDS_ADR_LSEL_FIRST;
   assign horiz_offset_low = {off_hi_r[`VDS_HORIZ_OFFSET_LOW_HI_MSB:0], horiz_offset_low_lo_r};
   assign vert_offset_low = {off_hi_r[`VDS_VERT_OFFSET_LOW_HI_BIT], vert_offset_low_lo_r};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gcfg_r <= `VDS_REG_RST;
         horiz_offset_low_lo_r <= `VDS_REG_RST;
         vert_offset_low_lo_r <= `VDS_REG_RST;
         off_hi_r <= `VDS_REG_RST;
         prog_fc_r <= `VDS_REG_RST;
         type_sel_r <= `VDS_REG_RST;
         for (int i = 0; i < `VDS_NUM_LSEL; i++) begin
            lsel_r[i] <= `VDS_LSEL_RST;
         end
      end else if (reg_wr) begin
         case (reg_addr)
            `VDS_ADR_GCFG: gcfg_r <= reg_wdata;
            `VDS_ADR_HORIZ_OFFSET_LOW_LO: horiz_offset_low_lo_r <= reg_wdata;
            `VDS_ADR_VERT_OFFSET_LOW_LO: vert_offset_low_lo_r <= reg_wdata;
            `VDS_ADR_OFF_HI: off_hi_r <= reg_wdata;
            `VDS_ADR_PROG_FC: prog_fc_r <= reg_wdata;
            `VDS_ADR_TYPE_SEL: type_sel_r <= reg_wdata;
            default: begin
               if (reg_addr >= `VDS_ADR_LSEL_FIRST && reg_addr <= `VDS_ADR_LSEL_LAST) begin
                  lsel_r[lsel_idx[4:0]] <= reg_wdata;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `VDS_ADR_GCFG: reg_rdata <= gcfg_r;
            `VDS_ADR_HORIZ_OFFSET_LOW_LO: reg_rdata <= horiz_offset_low_lo_r;
            `VDS_ADR_VERT_OFFSET_LOW_LO: reg_rdata <= vert_offset_low_lo_r;
            `VDS_ADR_OFF_HI: reg_rdata <= off_hi_r;
            `VDS_ADR_PROG_FC: reg_rdata <= prog_fc_r;
            `VDS_ADR_TYPE_SEL: reg_rdata <= type_sel_r;
            `VDS_ADR_STATUS: reg_rdata <= {sec_full_r, 2'h0, last_err_r};
            default: begin
               if (reg_addr >= `VDS_ADR_LSEL_FIRST && reg_addr <= `VDS_ADR_LSEL_LAST) begin
                  reg_rdata <= lsel_r[lsel_idx[4:0]];
               end else begin
                  reg_rdata <= 8'h00;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line and field timing

   logic horiz_reference_q_r;
   logic vt_q_r;
   logic h_fall;
   logic v_fall;
   logic [8:0] line_cnt_r;
   logic [8:0] lnum;
   logic fld;
   logic [8:0] lsel_pos;
   logic [7:0] lsel_byte;
   logic [3:0] code_next;

   assign h_fall = horiz_reference_q_r && !horiz_reference;
   assign v_fall = vt_q_r && !vert_timing_pulse;
   assign lnum = line_cnt_r - vert_offset_low;
   assign fld = field_id ^ off_hi_r[`VDS_FIELD_SLICE_OFFSET_BIT];
   // Lines past 24 keep the line-24 choice until the field restarts
   assign lsel_pos = (lnum > LAST_LINE) ? LAST_LINE - FIRST_LINE : lnum - FIRST_LINE;
   assign lsel_byte = lsel_r[lsel_pos[4:0]];

   always_comb begin
      if (line_cnt_r < vert_offset_low || lnum < FIRST_LINE) begin
         code_next = 4'hF;
      end else begin
         code_next = fld ? lsel_byte[7:4] : lsel_byte[3:0];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         horiz_reference_q_r <= 1'b0;
         vt_q_r <= 1'b0;
         line_cnt_r <= 9'h000;
      end else begin
         horiz_reference_q_r <= horiz_reference;
         vt_q_r <= vert_timing_pulse;
         if (v_fall) begin
            line_cnt_r <= 9'h000;
         end else if (h_fall && line_cnt_r != 9'h1FF) begin
            line_cnt_r <= line_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit recovery, framing search and byte packing

   vds_pkg::vds_std_t std_r;
   vds_pkg::vds_state_t state_r;
   logic [10:0] hcnt_r;
   logic [7:0] vmin_r;
   logic [7:0] vmax_r;
   logic [8:0] thr_sum;
   logic bit_now;
   logic bit_q_r;
   logic [23:0] phase_r;
   logic [24:0] phase_sum;
   logic sample;
   logic [23:0] sr_r;
   logic [23:0] sr_nxt;
   logic [7:0] bitcnt_r;
   logic [2:0] bitpos_r;
   logic [5:0] bcnt_r;
   logic [3:0] errs_r;
   logic [3:0] errs_nxt;
   logic ham_on;
   logic err_now;
   logic byte_done;
   logic framed;
   logic sec_w_r;
   logic [7:0] sec_mem_r [`VDS_NUM_SEC * `VDS_SEC_BYTES];
   logic [5:0] sec_len_r [`VDS_NUM_SEC];
   logic commit;
   logic sec_r_r;
   logic [5:0] rptr_r;
   logic drain;
   logic fifo_in_ready;
   logic [6:0] wr_index;
   logic [6:0] rd_index;

   assign thr_sum = {1'b0, vmin_r} + {1'b0, vmax_r};
   assign bit_now = vid_sample > thr_sum[8:1];
   assign phase_sum = {1'b0, phase_r} + {1'b0, std_r.inc};
   assign sample = phase_sum[24];
   assign sr_nxt = {bit_now, sr_r[23:1]};
   assign framed = (std_r.pat_len == 5'd0) ||
                   ((bitcnt_r + 8'd1 >= {3'b000, std_r.pat_len}) &&
                    ((sr_nxt >> (5'd24 - std_r.pat_len)) == std_r.pat));
   assign ham_on = (std_r.ham == vds_pkg::VDS_HAM_ALWAYS) ||
                   (std_r.ham == vds_pkg::VDS_HAM_OPTIONAL && type_sel_r[`VDS_HAM_EN_BIT]);
   assign byte_done = state_r == vds_pkg::VDS_ST_COLLECT && sample && bitpos_r == 3'd7;
   assign err_now = ham_on && bcnt_r < `VDS_HAM_BYTES && vds_ham_bad(sr_nxt[23:16]);
   assign errs_nxt = errs_r + {3'b000, err_now};
   // Only complete lines with tolerable errors reach a section
   assign commit = byte_done && bcnt_r == std_r.nbytes - 6'd1 &&
                   errs_nxt <= gcfg_r[`VDS_TOL_MSB:0] && !sec_full_r[sec_w_r];
   assign wr_index = (sec_w_r ? SEC_BYTES : 7'd0) + {1'b0, bcnt_r};
   assign rd_index = (sec_r_r ? SEC_BYTES : 7'd0) + {1'b0, rptr_r};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_r <= vds_pkg::VDS_ST_DONE;
         std_r <= '0;
         hcnt_r <= 11'h000;
      end else if (h_fall) begin
         state_r <= vds_pkg::VDS_ST_WAIT;
         std_r <= vds_lookup(code_next, prog_fc_r);
         hcnt_r <= 11'h000;
      end else begin
         case (state_r)
            vds_pkg::VDS_ST_WAIT: begin
               hcnt_r <= hcnt_r + 1'b1;
               if (std_r.nbytes == 6'd0) begin
                  state_r <= vds_pkg::VDS_ST_DONE;
               end else if (hcnt_r == horiz_offset_low) begin
                  state_r <= vds_pkg::VDS_ST_SEARCH;
               end
            end
            vds_pkg::VDS_ST_SEARCH: begin
               if (sample && framed) begin
                  state_r <= vds_pkg::VDS_ST_COLLECT;
               end else if (sample && bitcnt_r + 8'd1 >= std_r.win) begin
                  state_r <= vds_pkg::VDS_ST_DONE;
               end
            end
            vds_pkg::VDS_ST_COLLECT: begin
               if (byte_done && bcnt_r == std_r.nbytes - 6'd1) begin
                  state_r <= vds_pkg::VDS_ST_DONE;
               end
            end
            default: state_r <= vds_pkg::VDS_ST_DONE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         vmin_r <= 8'hFF;
         vmax_r <= 8'h00;
         bit_q_r <= 1'b0;
         phase_r <= 24'h000000;
         sr_r <= 24'h000000;
         bitcnt_r <= 8'h00;
      end else if (state_r == vds_pkg::VDS_ST_WAIT) begin
         vmin_r <= 8'hFF;
         vmax_r <= 8'h00;
         bit_q_r <= 1'b0;
         phase_r <= `VDS_PHASE_HALF;
         sr_r <= 24'h000000;
         bitcnt_r <= 8'h00;
      end else begin
         bit_q_r <= bit_now;
         if (state_r == vds_pkg::VDS_ST_SEARCH) begin
            if (vid_sample < vmin_r) begin
               vmin_r <= vid_sample;
            end
            if (vid_sample > vmax_r) begin
               vmax_r <= vid_sample;
            end
         end
         // Run-in edges pull the sampling point to mid-bit
         if (state_r == vds_pkg::VDS_ST_SEARCH && bit_now != bit_q_r && !sample) begin
            phase_r <= `VDS_PHASE_HALF;
         end else begin
            phase_r <= phase_sum[23:0];
         end
         if (sample) begin
            sr_r <= sr_nxt;
            if (bitcnt_r != 8'hFF) begin
               bitcnt_r <= bitcnt_r + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bitpos_r <= 3'd0;
         bcnt_r <= 6'd0;
         errs_r <= 4'h0;
      end else if (state_r != vds_pkg::VDS_ST_COLLECT) begin
         bitpos_r <= 3'd0;
         bcnt_r <= 6'd0;
         errs_r <= 4'h0;
      end else if (sample) begin
         bitpos_r <= bitpos_r + 1'b1;
         if (byte_done) begin
            bcnt_r <= bcnt_r + 1'b1;
            errs_r <= errs_nxt;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (byte_done && !sec_full_r[sec_w_r]) begin
         sec_mem_r[wr_index] <= sr_nxt[23:16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-section line buffer, drained into the output FIFO

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sec_w_r <= 1'b0;
         sec_r_r <= 1'b0;
         sec_full_r <= 2'b00;
         rptr_r <= 6'd0;
         last_err_r <= 4'h0;
         for (int i = 0; i < `VDS_NUM_SEC; i++) begin
            sec_len_r[i] <= 6'd0;
         end
      end else begin
         if (byte_done && bcnt_r == std_r.nbytes - 6'd1) begin
            last_err_r <= errs_nxt;
         end
         // Commit never targets the section being drained, so the set is never lost
         if (commit) begin
            sec_full_r[sec_w_r] <= 1'b1;
            sec_len_r[sec_w_r] <= std_r.nbytes;
            sec_w_r <= !sec_w_r;
         end
         if (drain) begin
            if (rptr_r == sec_len_r[sec_r_r] - 6'd1) begin
               sec_full_r[sec_r_r] <= 1'b0;
               sec_r_r <= !sec_r_r;
               rptr_r <= 6'd0;
            end else begin
               rptr_r <= rptr_r + 1'b1;
            end
         end
      end
   end

   assign drain = sec_full_r[sec_r_r] && fifo_in_ready;

   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [FIFO_WIDTH-1:0] fifo_out_data;

   vds_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .in_valid(drain),
      .in_ready(fifo_in_ready),
      .in_data(FIFO_WIDTH'(sec_mem_r[rd_index])),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_out_ready = !out_valid || out_ready;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data <= '0;
         line_avail <= 1'b0;
      end else begin
         line_avail <= |sec_full_r;
         if (fifo_out_ready) begin
            out_valid <= fifo_out_valid;
            out_data <= fifo_out_data;
         end
      end
   end
endmodule

//--- testbench/vds_slicer_asserts.sv
// Checker for the slicer's register port and byte stream
module vds_slicer_asserts #(
   parameter int FIFO_WIDTH = 8
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic out_valid,
   input wire logic [FIFO_WIDTH-1:0] out_data,
   input wire logic out_ready,
   input wire logic line_avail
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic [7:0] shadow_r [256];
   logic [7:0] exp_r;
   logic [2:0] idle_r;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 256; i++) shadow_r[i] <= (i > 8'h40 && i < 8'h58) ? 8'hFF : 8'h00;
      end else if (reg_wr) begin
         shadow_r[reg_addr] <= reg_wdata;
      end
   end
   // Captured at the strobe, as the port forbids write and read together
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) exp_r <= 8'h00;
      else if (reg_rd) exp_r <= shadow_r[reg_addr];
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) idle_r <= 3'h7;
      else if (line_avail) idle_r <= 3'h0;
      else if (idle_r != 3'h7) idle_r <= idle_r + 3'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   gcfg_read_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == exp_r)
      else $error("config readback wrong");
   lsel_read_a: assert property (reg_rd && reg_addr inside {[8'h41:8'h57]} |=> reg_rdata == exp_r)
      else $error("line select readback wrong");
   horiz_offset_low_read_a: assert property (reg_rd && reg_addr == 8'h59 |=> reg_rdata == exp_r)
      else $error("h offset readback wrong");
   vert_offset_low_read_a: assert property (reg_rd && reg_addr == 8'h5A |=> reg_rdata == exp_r)
      else $error("v offset readback wrong");
   offhi_read_a: assert property (reg_rd && reg_addr == 8'h5B |=> (reg_rdata & 8'h97) == (exp_r & 8'h97))
      else $error("offset high bits wrong");
   type_read_a: assert property (reg_rd && reg_addr == 8'h62 |=> reg_rdata == exp_r)
      else $error("type select readback wrong");
   unmapped_zero_a: assert property (reg_rd && reg_addr inside {8'h58, 8'h5D, [8'h5F:8'h61]} |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("byte dropped while stalled");
   avail_first_a: assert property ($rose(out_valid) |-> idle_r < 3'h5)
      else $error("byte without complete line");
   cover property (out_valid && out_ready);
   cover property (line_avail && out_valid && !out_ready);
   cover property (reg_rd && reg_addr == 8'h5E);
endmodule

//--- testbench/vds_video_src.sv
// Decoder-side source: timing edges and two-level sliced-data waveform
module vds_video_src (
   input wire logic clock,
   output logic [7:0] vid_sample,
   output logic horiz_reference,
   output logic vert_timing_pulse,
   output logic field_id
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      vid_sample = 8'h20;
      horiz_reference = 1'b1;
      vert_timing_pulse = 1'b1;
      field_id = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic field(input logic fid);
      field_id = fid;
      vert_timing_pulse = 1'b0;
      tick(4);
      vert_timing_pulse = 1'b1;
      tick(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Bits LSB first, 20 clocks each; idle level low so threshold stays centred
   task automatic line(input logic [135:0] bits, input int nbits);
      horiz_reference = 1'b0;
      tick(8);
      horiz_reference = 1'b1;
      tick(20);
      for (int i = 0; i < nbits; i++) begin
         vid_sample = bits[i] ? 8'hC0 : 8'h20;
         tick(20);
      end
      vid_sample = 8'h20;
      tick(300);
   endtask
endmodule

//--- testbench/vds_slicer_bench.sv
// Self-checking bench for the slicer: registers, sliced lines, stalls
module vds_slicer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, nrst, reg_wr, reg_rd, out_ready, out_valid, line_avail, hold, rd_d;
   logic horiz_reference, vert_timing_pulse, field_id;
   logic [7:0] vid_sample, reg_addr, reg_wdata, reg_rdata, out_data, d;
   logic [7:0] rq[$];
   logic [7:0] bq[$];
   logic [135:0] b;
   logic [31:0] seed = 32'h7554;
   int bad_count, comparisons;
   vds_slicer vds_slicer_inst (.clock(clock), .nrst(nrst), .vid_sample(vid_sample),
      .horiz_reference(horiz_reference), .vert_timing_pulse(vert_timing_pulse), .field_id(field_id),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .line_avail(line_avail));
   vds_video_src vds_video_src_inst (.clock(clock), .vid_sample(vid_sample), .horiz_reference(horiz_reference),
      .vert_timing_pulse(vert_timing_pulse), .field_id(field_id));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Strobe then one idle cycle, so no signal is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clock);
      #1 reg_wr = 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      rq.push_back(v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1 reg_rd = 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic vps(input logic good, input logic keep);
      b = {xs(), xs(), xs(), 8'(xs()), good ? 16'h9951 : 16'h9950, 16'h5555};
      for (int i = 0; i < 13; i++) if (keep) bq.push_back(b[32 + 8 * i +: 8]);
      vds_video_src_inst.line(b, 136);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      rd_d <= reg_rd;
      if (rd_d) check(reg_rdata, rq.size() ? rq.pop_front() : 8'hXX);
      if (out_valid === 1'b1 && out_ready === 1'b1) check(out_data, bq.size() ? bq.pop_front() : 8'hXX);
      out_ready <= #1 hold ? 1'b0 : 1'(xs());
   end
   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      conclude();
   end
   initial begin
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      hold = 1'b1;
      repeat (16) @(posedge clock);
      #1 nrst = 1'b1;
      for (int a = 8'h40; a <= 8'h62; a++) rd(8'(a), (a > 8'h40 && a < 8'h58) ? 8'hFF : 8'h00);
      for (int a = 8'h40; a <= 8'h62; a++) if (a != 8'h5B) begin
         d = 8'(xs());
         wr(8'(a), d);
         rd(8'(a), ((a < 8'h5B && a != 8'h58) || a == 8'h5C || a == 8'h62) ? d : 8'h00);
      end
      wr(8'h40, 8'h0F);
      for (int a = 8'h41; a < 8'h57; a++) wr(8'(a), 8'hFF);
      wr(8'h57, 8'hF2);
      wr(8'h59, 8'h10);
      wr(8'h5A, 8'h00);
      wr(8'h5B, 8'h00);
      wr(8'h62, 8'h00);
      vds_video_src_inst.field(1'b0);
      repeat (26) vds_video_src_inst.line('0, 0);
      // Three lines against a stalled reader: FIFO fills and a section waits
      repeat (3) vps(1'b1, 1'b1);
      check({7'h00, line_avail}, 8'h01);
      rd(8'h5E, 8'h40);
      hold = 1'b0;
      vps(1'b0, 1'b0);
      vds_video_src_inst.field(1'b1);
      repeat (26) vds_video_src_inst.line('0, 0);
      vps(1'b1, 1'b0);
      // Field offset flips back to the low nibble, so VPS slices again
      wr(8'h5B, 8'h80);
      vps(1'b1, 1'b1);
      for (int i = 0; i < 3000 && bq.size() != 0; i++) @(posedge clock);
      check(8'(bq.size()), 8'h00);
      conclude();
   end
endmodule
bind vds_slicer vds_slicer_asserts #(.FIFO_WIDTH(FIFO_WIDTH)) vds_slicer_asserts_inst (.clock(clock), .nrst(nrst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .line_avail(line_avail));
